//--- verilog/gpe_consts.svh
// Offsets, field positions, reset values and counts for the event-capable GPIO block
`ifndef GPE_CONSTS_SVH
`define GPE_CONSTS_SVH
`define GPE_NPINS 32
`define GPE_NEVPINS 16
`define GPE_CNT_W 8
`define GPE_DEB_CYCLES 16
`define GPE_OFF_DOUT0 4'h0
`define GPE_OFF_DIN0 4'h1
`define GPE_OFF_EVEN0 4'h2
`define GPE_OFF_EVST0 4'h3
`define GPE_OFF_DOUT1 4'h4
`define GPE_OFF_DIN1 4'h5
`define GPE_OFF_EVEN1 4'h6
`define GPE_OFF_EVST1 4'h7
`define GPE_OFF_DOUT2 4'h8
`define GPE_OFF_DIN2 4'h9
`define GPE_OFF_DOUT3 4'ha
`define GPE_OFF_DIN3 4'hb
`define GPE_IDX_ACT 8'h30
`define GPE_IDX_BAH 8'h60
`define GPE_IDX_BAL 8'h61
`define GPE_IDX_INTN 8'h70
`define GPE_IDX_INTT 8'h71
`define GPE_IDX_DMA_A 8'h74
`define GPE_IDX_DMA_B 8'h75
`define GPE_IDX_PSEL 8'hf0
`define GPE_IDX_PCFG 8'hf1
`define GPE_IDX_ROUTE 8'hf2
`define GPE_RST_ACT 8'h00
`define GPE_RST_BA 8'h00
`define GPE_RST_INTN 8'h00
`define GPE_RST_INTT 8'h03
`define GPE_DMA_NONE 8'h04
`define GPE_RST_PSEL 8'h00
`define GPE_RST_PCFG_EV 7'h44
`define GPE_RST_PCFG_PL 7'h04
`define GPE_RST_ROUTE 2'h1
`define GPE_MASK_PSEL 8'h37
`define GPE_MASK_BAL 8'hf0
`define GPE_MASK_PCFG_PL 7'h0f
`define GPE_INTT_WBIT 1
`define GPE_CFG_OE 0
`define GPE_CFG_OTYPE 1
`define GPE_CFG_PU 2
`define GPE_CFG_LOCK 3
`define GPE_CFG_ETYPE 4
`define GPE_CFG_EPOL 5
`define GPE_CFG_DEB 6
`define GPE_ROUTE_IRQ 0
`define GPE_ROUTE_MGMT 1
`define GPE_ACT_BIT 0
`define GPE_GLOBAL_BIT 7
`endif

//--- verilog/gpe_pkg.sv
// State types of the event-capable GPIO block
`include "gpe_consts.svh"
package gpe_pkg;
  typedef struct packed {
    logic [3:0][7:0] dout;
    logic [1:0][7:0] even;
    logic [1:0][7:0] evst;
    logic [`GPE_NPINS-1:0][6:0] pcfg;
    logic [`GPE_NEVPINS-1:0][1:0] route;
    logic [7:0] act;
    logic [7:0] bah;
    logic [7:0] bal;
    logic [7:0] intn;
    logic [7:0] intt;
    logic [7:0] psel;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
    logic mgmt;
    logic [`GPE_NPINS-1:0] pout;
    logic [`GPE_NPINS-1:0] oe_n;
    logic [`GPE_NPINS-1:0] pu;
  } gpe_state_t;

  typedef struct packed {
    logic [`GPE_NEVPINS-1:0] filt;
    logic [`GPE_NEVPINS-1:0] prev;
    logic [`GPE_NEVPINS-1:0] hit;
    logic [`GPE_NEVPINS-1:0][`GPE_CNT_W-1:0] cnt;
  } gpe_ev_state_t;
endpackage : gpe_pkg

//--- verilog/gpe_sync.sv
// Two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`include "gpe_consts.svh"
module gpe_sync #(
  parameter int WIDTH = `GPE_NPINS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // Reset to the pulled-up idle level
      meta_reg <= '1;
      q <= '1;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : gpe_sync

//--- verilog/gpe_event.sv
// Per-pin debounce and edge or level detection for ports 0 and 1
`timescale 1ns/1ps
`include "gpe_consts.svh"
module gpe_event #(
  parameter logic [`GPE_CNT_W-1:0] DEB_CYCLES = `GPE_CNT_W'(`GPE_DEB_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`GPE_NEVPINS-1:0] lvl,
  input wire logic [`GPE_NEVPINS-1:0] deb_en,
  input wire logic [`GPE_NEVPINS-1:0] pol_high,
  input wire logic [`GPE_NEVPINS-1:0] type_level,
  output logic [`GPE_NEVPINS-1:0] hit
);
  gpe_pkg::gpe_ev_state_t st_reg;
  gpe_pkg::gpe_ev_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    for (int i = 0; i < `GPE_NEVPINS; i++)
    begin
      if (!deb_en[i] || lvl[i] == st_reg.filt[i])
      begin
        st_next.cnt[i] = '0;
        st_next.filt[i] = lvl[i];
      end
      else if (st_reg.cnt[i] >= DEB_CYCLES - `GPE_CNT_W'(1))
      begin
        st_next.cnt[i] = '0;
        st_next.filt[i] = lvl[i];
      end
      else
      begin
        st_next.cnt[i] = st_reg.cnt[i] + `GPE_CNT_W'(1);
      end
      st_next.prev[i] = st_reg.filt[i];
      if (type_level[i])
        st_next.hit[i] = (st_reg.filt[i] == pol_high[i]);
      else
        st_next.hit[i] = (st_reg.filt[i] != st_reg.prev[i]) && (st_reg.filt[i] == pol_high[i]);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
      // Idle level high, so no false edge after reset
      st_reg.filt <= '1;
      st_reg.prev <= '1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign hit = st_reg.hit;
endmodule : gpe_event

//--- verilog/gpe_top.sv
// GPIO ports with event detection: runtime window, configuration space and pins
// Operation
// - Thirty-two pins in four eight-bit ports, each usable as input or output.
// - Port 0 and 1 pins detect events that raise interrupt or management requests.
// - Ports 2 and 3 have no event detection nor enable or status registers.
// - Runtime window is 16-byte aligned, offset taken from address bits 3 to 0.
// - Each event-capable pin owns a seven-bit configuration register.
// - Ports 2 and 3 configuration keep bits 3 to 0; bits 6 to 4 reserved.
// - Activation at 30h resets to 00h and depends on global bit 7.
// - Base address bytes at 60h and 61h reset 00h; low nibble reads zero.
// - Interrupt number register at 70h, read-write, reset 00h.
// - Interrupt type at 71h resets to 03h, only bit 1 writable.
// - Indexes 74h and 75h read-only, always 04h.
// - Pin select F0h resets 00h, configuration F1h 44h, routing F2h 01h.
// - Pin select bits 5-4 pick port, bits 2-0 pick pin.
// - Configuration window reaches selected pin; reset 44h ports 0-1, 04h ports 2-3.
// - Bit 6 debounce, bit 5 polarity, bit 4 edge or level.
// - Lock bit once set stays set until system reset.
`timescale 1ns/1ps
`include "gpe_consts.svh"
module gpe_top #(
  parameter logic [`GPE_CNT_W-1:0] DEB_CYCLES = `GPE_CNT_W'(`GPE_DEB_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic rt_wr,
  input wire logic rt_rd,
  input wire logic [7:0] cfg_index,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] global_configuration_one,
  input wire logic [`GPE_NPINS-1:0] pin_in,
  output logic [`GPE_NPINS-1:0] pin_out,
  output logic [`GPE_NPINS-1:0] pin_oe_n,
  output logic [`GPE_NPINS-1:0] pin_pullup_en,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic irq_req,
  output logic system_management_interrupt,
  output logic [7:0] irq_select,
  output logic irq_type
);
  gpe_pkg::gpe_state_t st_reg;
  gpe_pkg::gpe_state_t st_next;
  logic [`GPE_NPINS-1:0] pin_sync;
  logic [`GPE_NEVPINS-1:0] ev_hit;
  logic [`GPE_NEVPINS-1:0] ev_deb;
  logic [`GPE_NEVPINS-1:0] ev_pol;
  logic [`GPE_NEVPINS-1:0] ev_type;
  logic rt_sel;
  logic [4:0] sel_pin;

  function automatic logic [4:0] pin_index(input logic [7:0] psel);
    pin_index = {psel[5:4], psel[2:0]};
  endfunction : pin_index

  // Ports 0 and 1 carry event logic
  function automatic logic is_event_pin(input logic [4:0] idx);
    is_event_pin = (idx[4] == 1'b0);
  endfunction : is_event_pin

  gpe_sync #(
    .WIDTH(`GPE_NPINS)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d(pin_in),
    .q(pin_sync)
  );

  // Event fields unpacked per pin for the detector
  genvar g;
  generate
    for (g = 0; g < `GPE_NEVPINS; g++)
    begin : g_evcfg
      assign ev_deb[g] = st_reg.pcfg[g][`GPE_CFG_DEB];
      assign ev_pol[g] = st_reg.pcfg[g][`GPE_CFG_EPOL];
      assign ev_type[g] = st_reg.pcfg[g][`GPE_CFG_ETYPE];
    end
  endgenerate

  // detection on ports 0 and 1 only
  gpe_event #(
    .DEB_CYCLES(DEB_CYCLES)
  ) u_event (
    .clk(clk),
    .rst(rst),
    .lvl(pin_sync[`GPE_NEVPINS-1:0]),
    .deb_en(ev_deb),
    .pol_high(ev_pol),
    .type_level(ev_type),
    .hit(ev_hit)
  );

  // Window closed while inactive, so stray cycles never hit it
  // window match on address bits 15 to 4
  assign rt_sel = st_reg.act[`GPE_ACT_BIT]
    && (io_addr[15:4] == {st_reg.bah, st_reg.bal[7:4]});
  // New select takes effect the cycle after its write
  assign sel_pin = pin_index(st_reg.psel);

  always_comb
  begin
    logic [1:0][7:0] clr;
    logic irq_any;
    logic mgmt_any;
    logic [7:0] cfg_rdata;
    clr = '0;
    irq_any = 1'b0;
    mgmt_any = 1'b0;
    cfg_rdata = 8'h00;
    st_next = st_reg;
    // Read answer is a one-cycle pulse
    st_next.rvalid = 1'b0;

    if (rt_sel && rt_wr)
    begin
      unique case (io_addr[3:0])
        `GPE_OFF_DOUT0: st_next.dout[0] = wr_data;
        `GPE_OFF_DOUT1: st_next.dout[1] = wr_data;
        `GPE_OFF_DOUT2: st_next.dout[2] = wr_data;
        `GPE_OFF_DOUT3: st_next.dout[3] = wr_data;
        `GPE_OFF_EVEN0: st_next.even[0] = wr_data;
        `GPE_OFF_EVEN1: st_next.even[1] = wr_data;
        `GPE_OFF_EVST0: clr[0] = wr_data;
        `GPE_OFF_EVST1: clr[1] = wr_data;
        // input data and unused offsets ignore writes
        default: ;
      endcase
    end

    for (int p = 0; p < 2; p++)
    begin
      st_next.evst[p] = (st_reg.evst[p] & ~clr[p]) | (ev_hit[p*8 +: 8] & st_reg.even[p]);
    end

    if (rt_sel && rt_rd)
    begin
      st_next.rvalid = 1'b1;
      unique case (io_addr[3:0])
        `GPE_OFF_DOUT0: st_next.rdata = st_reg.dout[0];
        `GPE_OFF_DOUT1: st_next.rdata = st_reg.dout[1];
        `GPE_OFF_DOUT2: st_next.rdata = st_reg.dout[2];
        `GPE_OFF_DOUT3: st_next.rdata = st_reg.dout[3];
        `GPE_OFF_DIN0: st_next.rdata = pin_sync[7:0];
        `GPE_OFF_DIN1: st_next.rdata = pin_sync[15:8];
        `GPE_OFF_DIN2: st_next.rdata = pin_sync[23:16];
        `GPE_OFF_DIN3: st_next.rdata = pin_sync[31:24];
        `GPE_OFF_EVEN0: st_next.rdata = st_reg.even[0];
        `GPE_OFF_EVEN1: st_next.rdata = st_reg.even[1];
        `GPE_OFF_EVST0: st_next.rdata = st_reg.evst[0];
        `GPE_OFF_EVST1: st_next.rdata = st_reg.evst[1];
        // no event registers above port 1
        default: st_next.rdata = 8'h00;
      endcase
    end

    // Decoded every cycle, latched only on a config read
    unique case (cfg_index)
      `GPE_IDX_ACT: cfg_rdata = st_reg.act;
      `GPE_IDX_BAH: cfg_rdata = st_reg.bah;
      `GPE_IDX_BAL: cfg_rdata = st_reg.bal;
      `GPE_IDX_INTN: cfg_rdata = st_reg.intn;
      `GPE_IDX_INTT: cfg_rdata = st_reg.intt;
      `GPE_IDX_DMA_A: cfg_rdata = `GPE_DMA_NONE;
      `GPE_IDX_DMA_B: cfg_rdata = `GPE_DMA_NONE;
      `GPE_IDX_PSEL: cfg_rdata = st_reg.psel;
      `GPE_IDX_PCFG: cfg_rdata = {1'b0, st_reg.pcfg[sel_pin]};
      `GPE_IDX_ROUTE:
        cfg_rdata = is_event_pin(sel_pin) ? {6'h00, st_reg.route[sel_pin[3:0]]} : 8'h00;
      default: cfg_rdata = 8'h00;
    endcase
    // Placed last, so a config read wins over a runtime read
    if (cfg_rd)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata = cfg_rdata;
    end

    if (cfg_wr)
    begin
      unique case (cfg_index)
        // activation frozen while global bit 7 set
        `GPE_IDX_ACT:
        begin
          if (!global_configuration_one[`GPE_GLOBAL_BIT])
            st_next.act = wr_data;
        end
        `GPE_IDX_BAH: st_next.bah = wr_data;
        `GPE_IDX_BAL: st_next.bal = wr_data & `GPE_MASK_BAL;
        `GPE_IDX_INTN: st_next.intn = wr_data;
        `GPE_IDX_INTT: st_next.intt[`GPE_INTT_WBIT] = wr_data[`GPE_INTT_WBIT];
        `GPE_IDX_PSEL: st_next.psel = wr_data & `GPE_MASK_PSEL;
        `GPE_IDX_PCFG:
        begin
          // seven bits per pin
          // Lock also refuses a write that would clear it
          // locked pin ignores writes, lock sticks
          if (!st_reg.pcfg[sel_pin][`GPE_CFG_LOCK])
          begin
            // upper ports keep bits 3 to 0 only
            if (is_event_pin(sel_pin))
              st_next.pcfg[sel_pin] = wr_data[6:0];
            else
              st_next.pcfg[sel_pin] = wr_data[6:0] & `GPE_MASK_PCFG_PL;
          end
        end
        `GPE_IDX_ROUTE:
        begin
          if (is_event_pin(sel_pin))
            st_next.route[sel_pin[3:0]] = wr_data[1:0];
        end
        default: ;
      endcase
    end

    // Registered, so the host never sees a decode glitch
    // pending and enabled events reach routed request
    for (int i = 0; i < `GPE_NEVPINS; i++)
    begin
      if (st_reg.evst[i/8][i%8] && st_reg.even[i/8][i%8])
      begin
        irq_any = irq_any | st_reg.route[i][`GPE_ROUTE_IRQ];
        mgmt_any = mgmt_any | st_reg.route[i][`GPE_ROUTE_MGMT];
      end
    end
    st_next.irq = irq_any && st_reg.act[`GPE_ACT_BIT];
    st_next.mgmt = mgmt_any && st_reg.act[`GPE_ACT_BIT];

    // drivers per pin; open drain drives only low
    for (int i = 0; i < `GPE_NPINS; i++)
    begin
      st_next.pout[i] = st_reg.dout[i/8][i%8];
      st_next.oe_n[i] = !(st_reg.pcfg[i][`GPE_CFG_OE]
        && (!st_reg.pcfg[i][`GPE_CFG_OTYPE] || !st_reg.dout[i/8][i%8]));
      st_next.pu[i] = st_reg.pcfg[i][`GPE_CFG_PU];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.act <= `GPE_RST_ACT;
      st_reg.bah <= `GPE_RST_BA;
      st_reg.bal <= `GPE_RST_BA;
      st_reg.intn <= `GPE_RST_INTN;
      st_reg.intt <= `GPE_RST_INTT;
      st_reg.psel <= `GPE_RST_PSEL;
      st_reg.oe_n <= '1;
      // Pull-ups on from reset, matching the configuration reset
      st_reg.pu <= '1;
      for (int i = 0; i < `GPE_NPINS; i++)
      begin
        st_reg.pcfg[i] <= (i < `GPE_NEVPINS) ? `GPE_RST_PCFG_EV : `GPE_RST_PCFG_PL;
      end
      for (int i = 0; i < `GPE_NEVPINS; i++)
      begin
        st_reg.route[i] <= `GPE_RST_ROUTE;
      end
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign pin_out = st_reg.pout;
  assign pin_oe_n = st_reg.oe_n;
  assign pin_pullup_en = st_reg.pu;
  assign rd_data = st_reg.rdata;
  assign rd_valid = st_reg.rvalid;
  assign irq_req = st_reg.irq;
  assign system_management_interrupt = st_reg.mgmt;
  assign irq_select = st_reg.intn;
  assign irq_type = st_reg.intt[`GPE_INTT_WBIT];
endmodule : gpe_top

//--- bench/gpe_top_props.sv
// Port-level assertions for the GPIO block with event detection
`timescale 1ns/1ps
module gpe_top_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic rt_wr,
  input wire logic rt_rd,
  input wire logic [7:0] cfg_index,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_pullup_en,
  input wire logic [7:0] irq_select,
  input wire logic irq_type
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_cfg_read_ans: assert property (cfg_rd |=> rd_valid)
    else $error("config read gave no answer");
  a_valid_cause: assert property (rd_valid |-> $past(cfg_rd || rt_rd))
    else $error("read answer without a read");
  a_dma_fixed: assert property (
    cfg_rd && (cfg_index == 8'h74 || cfg_index == 8'h75) |=> rd_data == 8'h04)
    else $error("dma report not 04");
  a_base_low_nib: assert property (
    cfg_rd && cfg_index == 8'h61 |=> rd_data[3:0] == 4'h0)
    else $error("base low nibble not zero");
  a_select_mask: assert property (
    cfg_rd && cfg_index == 8'hf0 |=> (rd_data & 8'hc8) == 8'h00)
    else $error("pin select reserved bits set");
  a_hole_reads_zero: assert property (
    rt_rd && !cfg_rd && io_addr[3:0] > 4'hb |=> !rd_valid || rd_data == 8'h00)
    else $error("unused offset read not zero");
  a_type_by_write: assert property ($changed(irq_type) |->
    $past(cfg_wr && cfg_index == 8'h71) || $past(cfg_wr && cfg_index == 8'h71, 2))
    else $error("interrupt type moved without write");
  a_select_by_write: assert property ($changed(irq_select) |->
    $past(cfg_wr && cfg_index == 8'h70) || $past(cfg_wr && cfg_index == 8'h70, 2))
    else $error("interrupt number moved without write");
  a_dout_by_write: assert property (
    $changed(pin_out) |-> $past(rt_wr) || $past(rt_wr, 2))
    else $error("pin output moved without write");
  a_pullup_by_cfg: assert property ($changed(pin_pullup_en) |->
    $past(cfg_wr && cfg_index == 8'hf1) || $past(cfg_wr && cfg_index == 8'hf1, 2))
    else $error("pull-up moved without config write");
  c_pin_cfg: cover property (cfg_wr && cfg_index == 8'hf1);
  c_rt_read: cover property (rt_rd ##1 rd_valid);
  c_dout_move: cover property ($changed(pin_out));
endmodule : gpe_top_props

//--- bench/gpe_pin_model.sv
// External pins: device drivers, pull-ups and bench stimulus
`timescale 1ns/1ps
module gpe_pin_model (
  input wire logic clk,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  input wire logic [31:0] pin_pullup_en,
  input wire logic [31:0] ext_val,
  input wire logic [31:0] ext_en,
  output logic [31:0] pin_in
);
  logic [31:0] last = '0;
  always_ff @(posedge clk)
  begin
    last <= pin_in;
  end
  // Device drive wins
  // A floating pin flips, so a stale level never reads back
  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      if (pin_oe_n[i] === 1'b0)
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup_en[i] === 1'b1)
        pin_in[i] = 1'b1;
      else
        pin_in[i] = ~last[i];
    end
  end
endmodule : gpe_pin_model

//--- bench/gpio_ports_with_event_detect_bench.sv
// Self-checking bench for the GPIO block with event detection
`timescale 1ns/1ps
module gpio_ports_with_event_detect_bench;
  logic clk = 0, rst = 1, rt_wr = 0, rt_rd = 0, cfg_wr = 0, cfg_rd = 0;
  logic rd_valid, irq_req, mgmt_req, irq_type;
  logic [15:0] io_addr = '0;
  logic [11:0] base = 12'h123;
  logic [7:0] cfg_index = '0, wr_data = '0, gcfg = '0, rd_data, irq_select, v;
  logic [31:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, ext_val = '0, ext_en = '0;
  int num_errors = 0, n_compared = 0;
  logic [7:0] ti [10] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75, 8'hf0, 8'hf1, 8'hf2};
  logic [7:0] tv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h04, 8'h04, 8'h00, 8'h44, 8'h01};
  logic [7:0] wi [5] = '{8'h61, 8'h71, 8'h74, 8'h70, 8'hf0};
  logic [7:0] wd [5] = '{8'hff, 8'h00, 8'h00, 8'h5a, 8'hff};
  logic [7:0] we [5] = '{8'hf0, 8'h01, 8'h04, 8'h5a, 8'h37};

  gpe_top #(.DEB_CYCLES(8'h02)) gpe_top_inst (.clk(clk), .rst(rst), .io_addr(io_addr),
    .rt_wr(rt_wr), .rt_rd(rt_rd), .cfg_index(cfg_index), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .wr_data(wr_data), .global_configuration_one(gcfg), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en), .rd_data(rd_data),
    .rd_valid(rd_valid), .irq_req(irq_req), .system_management_interrupt(mgmt_req),
    .irq_select(irq_select), .irq_type(irq_type));
  gpe_pin_model gpe_pin_model_inst (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop;
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Strobe for one edge, then wait a bounded time for the read answer
  task automatic acc(input logic rt, input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(negedge clk);
    io_addr = {base, a[3:0]};
    cfg_index = a;
    wr_data = d;
    {rt_wr, rt_rd, cfg_wr, cfg_rd} = {rt & w, rt & !w, !rt & w, !rt & !w};
    @(negedge clk);
    {rt_wr, rt_rd, cfg_wr, cfg_rd} = 4'h0;
    for (k = 0; k < 4 && !w && rd_valid !== 1'b1; k++)
      @(negedge clk);
    if (k == 4)
    begin
      num_errors++;
      report_and_stop();
    end
    v = rd_data;
  endtask : acc

  task automatic cr(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, 1'b0, a, 8'h00);
    check(v, e);
  endtask : cr

  task automatic rr(input logic [7:0] a, input logic [7:0] e);
    acc(1'b1, 1'b0, a, 8'h00);
    check(v, e);
  endtask : rr

  task automatic miss;
    @(negedge clk);
    io_addr = {base, 4'h1};
    rt_rd = 1'b1;
    @(negedge clk);
    rt_rd = 1'b0;
    repeat (2)
    begin
      check(rd_valid, 1'b0);
      @(negedge clk);
    end
  endtask : miss

  // Bounded wait for a request output to reach a level
  task automatic wait_req(input logic use_mgmt, input logic e);
    logic s;
    for (int k = 0; k < 40; k++)
    begin
      @(negedge clk);
      s = use_mgmt ? mgmt_req : irq_req;
      if (s === e)
        break;
    end
    check(s, e);
    if (s !== e)
      report_and_stop();
  endtask : wait_req

  initial
  begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (5) @(negedge clk);
    rst = 0;
    check(pin_oe_n, 32'hffffffff);
    check(irq_type, 1'b1);
    for (int i = 0; i < 10; i++)
      cr(ti[i], tv[i]);
    for (int i = 0; i < 5; i++)
    begin
      acc(1'b0, 1'b1, wi[i], wd[i]);
      cr(wi[i], we[i]);
    end
    check({irq_select, 7'h00, irq_type}, 16'h5a00);
    acc(1'b0, 1'b1, 8'h60, 8'h12);
    acc(1'b0, 1'b1, 8'h61, 8'h30);
    miss();
    gcfg = 8'h80;
    acc(1'b0, 1'b1, 8'h30, 8'h01);
    cr(8'h30, 8'h00);
    gcfg = 8'h00;
    acc(1'b0, 1'b1, 8'h30, 8'h01);
    cr(8'h30, 8'h01);
    base = 12'h124;
    miss();
    base = 12'h123;
    for (int p = 0; p < 4; p++)
    begin
      acc(1'b1, 1'b1, 8'(p < 2 ? 4 * p : 8 + 2 * (p - 2)), 8'(8'h11 * (p + 1)));
      acc(1'b1, 1'b1, 8'(p < 2 ? 4 * p + 1 : 9 + 2 * (p - 2)), 8'hff);
    end
    check(pin_out, 32'h44332211);
    ext_en = 32'hffffffff;
    ext_val = 32'ha5c33c5a;
    rr(8'h00, 8'h11);
    rr(8'h0a, 8'h44);
    rr(8'h01, 8'h5a);
    rr(8'h05, 8'h3c);
    rr(8'h09, 8'hc3);
    rr(8'h0b, 8'ha5);
    rr(8'h0d, 8'h00);
    ext_en = 32'h00000100;
    ext_val = 32'h0;
    acc(1'b0, 1'b1, 8'hf0, 8'h23);
    acc(1'b0, 1'b1, 8'hf1, 8'h7f);
    cr(8'hf1, 8'h0f);
    check(pin_oe_n[19], 1'b0);
    acc(1'b0, 1'b1, 8'hf1, 8'h00);
    cr(8'hf1, 8'h0f);
    cr(8'hf2, 8'h00);
    acc(1'b1, 1'b1, 8'h03, 8'hff);
    acc(1'b0, 1'b1, 8'hf0, 8'h01);
    acc(1'b0, 1'b1, 8'hf1, 8'h04);
    acc(1'b1, 1'b1, 8'h02, 8'h02);
    cr(8'hf1, 8'h04);
    rr(8'h02, 8'h02);
    ext_en[1] = 1'b1;
    wait_req(1'b0, 1'b1);
    rr(8'h03, 8'h02);
    acc(1'b1, 1'b1, 8'h03, 8'h00);
    rr(8'h03, 8'h02);
    acc(1'b1, 1'b1, 8'h03, 8'h02);
    rr(8'h03, 8'h00);
    wait_req(1'b0, 1'b0);
    // Short low glitch must not pass the debounce filter
    acc(1'b1, 1'b1, 8'h02, 8'h04);
    ext_en[2] = 1'b1;
    @(negedge clk);
    ext_en[2] = 1'b0;
    repeat (6) @(negedge clk);
    rr(8'h03, 8'h00);
    ext_en[2] = 1'b1;
    wait_req(1'b0, 1'b1);
    rr(8'h03, 8'h04);
    acc(1'b1, 1'b1, 8'h03, 8'h04);
    wait_req(1'b0, 1'b0);
    acc(1'b0, 1'b1, 8'hf0, 8'h10);
    acc(1'b0, 1'b1, 8'hf1, 8'h34);
    acc(1'b0, 1'b1, 8'hf2, 8'h02);
    acc(1'b1, 1'b1, 8'h07, 8'hff);
    acc(1'b1, 1'b1, 8'h06, 8'h01);
    ext_en[8] = 1'b0;
    wait_req(1'b1, 1'b1);
    check(irq_req, 1'b0);
    acc(1'b1, 1'b1, 8'h07, 8'h01);
    rr(8'h07, 8'h01);
    ext_en[8] = 1'b1;
    repeat (8) @(negedge clk);
    acc(1'b1, 1'b1, 8'h07, 8'h01);
    rr(8'h07, 8'h00);
    wait_req(1'b1, 1'b0);
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    acc(1'b0, 1'b1, 8'hf0, 8'h23);
    cr(8'hf1, 8'h04);
    report_and_stop();
  end
endmodule : gpio_ports_with_event_detect_bench

bind gpe_top gpe_top_props gpe_top_props_inst (.clk(clk), .rst(rst), .io_addr(io_addr),
  .rt_wr(rt_wr), .rt_rd(rt_rd), .cfg_index(cfg_index), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .rd_data(rd_data), .rd_valid(rd_valid), .pin_out(pin_out), .pin_pullup_en(pin_pullup_en),
  .irq_select(irq_select), .irq_type(irq_type));
